/* logic/led_i2c_pkg.sv */
/*
  shared constants and types for the two-wire target of the matrix led
  driver and for the bus controller that drives it.
  assumes a single 20 mhz reference clock on both ends.
*/
package led_i2c_pkg;
  localparam int unsigned REF_CLK_KHZ = 20000;
  localparam int unsigned SCL_STD_KHZ = 100;
  localparam int unsigned SCL_FAST_KHZ = 400;
  // a quarter bit period is a least time, so it rounds up
  localparam int unsigned QTR_STD_CYC = (REF_CLK_KHZ + 4 * SCL_STD_KHZ - 1) / (4 * SCL_STD_KHZ);
  localparam int unsigned QTR_FAST_CYC = (REF_CLK_KHZ + 4 * SCL_FAST_KHZ - 1) / (4 * SCL_FAST_KHZ);
  localparam logic [7:0] QTR_STD_M1 = 8'(QTR_STD_CYC - 1);
  localparam logic [7:0] QTR_FAST_M1 = 8'(QTR_FAST_CYC - 1);
  localparam int unsigned OSC_KHZ = 4000;
  localparam int unsigned OSC_DIV = REF_CLK_KHZ / OSC_KHZ;
  localparam logic [2:0] OSC_DIV_M1 = 3'(OSC_DIV - 1);
  localparam logic [2:0] OSC_HI_CYC = 3'(OSC_DIV / 2);
  localparam int unsigned SOFT_RST_US = 1000;
  localparam int unsigned SOFT_RST_CYC = SOFT_RST_US * REF_CLK_KHZ / 1000;
  localparam int unsigned WAIT_W = 16;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] ADDR_SEL_LO = 7'h3a;
  localparam logic [6:0] ADDR_SEL_HI = 7'h3b;
  // target register map
  localparam logic [7:0] REG_ID = 8'h00;
  localparam logic [7:0] REG_SLEEP = 8'h01;
  localparam logic [7:0] REG_SOFT_RST = 8'h02;
  localparam logic [7:0] REG_LED_MODE = 8'h03;
  localparam logic [7:0] REG_UPDATE = 8'h04;
  localparam logic [7:0] REG_CLK_SYS = 8'h05;
  localparam logic [7:0] REG_CFG_FIRST = 8'h10;
  localparam logic [7:0] REG_MEM_LAST = 8'h7f;
  localparam int unsigned MEM_DEPTH = 128;
  localparam logic [7:0] SLEEP_STANDBY = 8'h80;
  localparam logic [7:0] SLEEP_ACTIVE = 8'h00;
  localparam logic [7:0] SOFT_RST_CMD = 8'h01;
  localparam logic [7:0] LED_MODE_RST = 8'h10;
  localparam int unsigned CLK_IO_BIT = 0;
  localparam int unsigned CLK_SEL_BIT = 1;
  // synchronised pin indices and their levels under reset
  localparam int unsigned PIN_SCL = 0;
  localparam int unsigned PIN_SDA = 1;
  localparam int unsigned PIN_ADDR_SEL = 2;
  localparam int unsigned PIN_SHUTDOWN = 3;
  localparam int unsigned PIN_CLK = 4;
  localparam int unsigned PIN_N = 5;
  localparam logic [4:0] PIN_RST_LVL = 5'h0b;
  // controller register port
  localparam logic [2:0] H_CTRL = 3'h0;
  localparam logic [2:0] H_DEV = 3'h1;
  localparam logic [2:0] H_REG = 3'h2;
  localparam logic [2:0] H_WDATA = 3'h3;
  localparam logic [2:0] H_RDATA = 3'h4;
  localparam logic [2:0] H_STATUS = 3'h5;
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_READ = 1;
  localparam int unsigned CTRL_FAST = 2;
  localparam logic [1:0] BI_ADDR = 2'h0;
  localparam logic [1:0] BI_REG = 2'h1;
  localparam logic [1:0] BI_RADDR = 2'h2;
  localparam logic [1:0] BI_RDATA = 2'h3;
  typedef enum logic [1:0] {mode_shutdown, mode_standby, mode_active} mode_e;
endpackage : led_i2c_pkg

/* logic/two_wire_if.sv */
/*
  two-wire link between the bus controller and the led driver target.
  both lines are open drain; the wired level is resolved here from the
  enables, a released line reads high as if pulled up.
*/
`timescale 1ns/10ps
interface two_wire_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_t_o;
  logic sda_t_oe;
  logic scl;
  logic sda;
  // wired-and of every driver that is enabled
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_t_oe && !sda_t_o));
  modport target (input scl, input sda, output sda_t_o, output sda_t_oe);
  modport controller (input sda, output scl_m_o, output scl_m_oe, output sda_m_o,
    output sda_m_oe);
endinterface : two_wire_if

/* logic/pin_sync.sv */
/*
  three-stage synchroniser for a pin from outside the clock domain.
  the level follows once the second and third stage agree.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter logic RST_LVL = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic [2:0] ff;
    logic lvl;
  } sync_s;
  sync_s q;
  sync_s d;

  // stage one is only read by stage two, so a metastable value never reaches logic
  always_comb begin
    d = q;
    d.ff = {q.ff[1:0], pin};
    if (q.ff[1] == q.ff[2]) begin
      d.lvl = q.ff[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= {{3{RST_LVL}}, RST_LVL};
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
endmodule : pin_sync

/* logic/led_target.sv */
/*
  two-wire target of the matrix led driver: address match, register
  writes and reads with auto-increment, operating modes, the three reset
  sources and the clock pin direction and source.
  assumes the controller keeps data stable while the clock is high and
  respects the wait after a soft reset.
*/
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
module led_target #(
  parameter int unsigned RST_WAIT_CYC = led_i2c_pkg::SOFT_RST_CYC,
  parameter logic [7:0] CHIP_ID = 8'h5a // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst,
  two_wire_if.target bus,
  input wire logic addr_sel_pin,
  input wire logic shutdown_pin_n,
  input wire logic clock_in_out_pin_i,
  output logic clock_in_out_pin_o,
  output logic clock_in_out_pin_oe,
  output led_i2c_pkg::mode_e mode,
  output logic led_drive_en,
  output logic core_clk_en,
  output logic update_req,
  output logic reset_busy
);
  typedef enum logic [2:0] {
    st_idle, st_addr, st_reg, st_wdat, st_ack, st_rdat, st_mack, st_wait
  } st_e;
  typedef struct packed {
    st_e st;
    st_e after;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic mack;
    logic sda_oe;
    logic scl_p;
    logic sda_p;
    logic clk_p;
    led_i2c_pkg::mode_e mode;
    logic led_en;
    logic [led_i2c_pkg::MEM_DEPTH-1:0][7:0] mem;
    logic [led_i2c_pkg::WAIT_W-1:0] busy;
    logic rbusy;
    logic [2:0] div;
    logic clk_o;
    logic core_en;
    logic upd;
  } tgt_s;

  tgt_s q;
  tgt_s d;
  logic [led_i2c_pkg::PIN_N-1:0] raw;
  logic [led_i2c_pkg::PIN_N-1:0] lvl;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic [6:0] own_addr;

  // defaults for every piece of state, shared by all three reset sources
  function automatic tgt_s tgt_init();
    tgt_init = '0;
    tgt_init.st = st_idle;
    tgt_init.after = st_idle;
    tgt_init.scl_p = 1'b1;
    tgt_init.sda_p = 1'b1;
    // divider parked at its wrap so the first pin pulse after reset is full width
    tgt_init.div = led_i2c_pkg::OSC_DIV_M1;
    tgt_init.mode = led_i2c_pkg::mode_standby;
    tgt_init.mem[led_i2c_pkg::REG_SLEEP[6:0]] = led_i2c_pkg::SLEEP_STANDBY;
    tgt_init.mem[led_i2c_pkg::REG_LED_MODE[6:0]] = led_i2c_pkg::LED_MODE_RST;
  endfunction : tgt_init

  // the same defaults as a constant, for the soft reset of the register file
  localparam tgt_s TGT_RST = tgt_init();

  // write-only and unmapped locations read as zero
  function automatic logic [7:0] rd_byte(input tgt_s s);
    if (s.ptr == led_i2c_pkg::REG_ID) begin
      rd_byte = CHIP_ID;
    end else if (s.ptr == led_i2c_pkg::REG_SOFT_RST || s.ptr == led_i2c_pkg::REG_UPDATE ||
                 s.ptr > led_i2c_pkg::REG_MEM_LAST) begin
      rd_byte = 8'h00;
    end else begin
      rd_byte = s.mem[s.ptr[6:0]];
    end
  endfunction : rd_byte

  // every outside pin goes through its own synchroniser
  assign raw[led_i2c_pkg::PIN_SCL] = bus.scl;
  assign raw[led_i2c_pkg::PIN_SDA] = bus.sda;
  assign raw[led_i2c_pkg::PIN_ADDR_SEL] = addr_sel_pin;
  assign raw[led_i2c_pkg::PIN_SHUTDOWN] = shutdown_pin_n;
  assign raw[led_i2c_pkg::PIN_CLK] = clock_in_out_pin_i;
  for (genvar gi = 0; gi < led_i2c_pkg::PIN_N; gi++) begin : g_sync
    pin_sync #(
      .RST_LVL(led_i2c_pkg::PIN_RST_LVL[gi])
    ) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin(raw[gi]),
      .level(lvl[gi])
    );
  end

  // bus events from the synchronised lines; an edge of data while the clock
  // stays high is a start or a stop, wherever it falls in a transfer
  assign scl = lvl[led_i2c_pkg::PIN_SCL];
  assign sda = lvl[led_i2c_pkg::PIN_SDA];
  assign scl_rise = scl && !q.scl_p;
  assign scl_fall = !scl && q.scl_p;
  assign start_ev = q.scl_p && scl && q.sda_p && !sda;
  assign stop_ev = q.scl_p && scl && !q.sda_p && sda;
  assign own_addr = lvl[led_i2c_pkg::PIN_ADDR_SEL] ? led_i2c_pkg::ADDR_SEL_HI :
                    led_i2c_pkg::ADDR_SEL_LO;

  // next state of the whole target
  always_comb begin
    d = q;
    d.scl_p = scl;
    d.sda_p = sda;
    d.clk_p = lvl[led_i2c_pkg::PIN_CLK];
    d.upd = 1'b0;
    if (!q.mem[led_i2c_pkg::REG_CLK_SYS[6:0]][led_i2c_pkg::CLK_IO_BIT] &&
        q.mem[led_i2c_pkg::REG_CLK_SYS[6:0]][led_i2c_pkg::CLK_SEL_BIT]) begin
      d.core_en = lvl[led_i2c_pkg::PIN_CLK] && !q.clk_p;
    end else begin
      d.core_en = (q.div == led_i2c_pkg::OSC_DIV_M1);
    end
    if (q.busy != '0) begin
      d.busy = q.busy - 16'h0001;
    end

    // serial engine; while the soft reset settles a start is not taken
    if (stop_ev) begin
      d.st = st_idle;
      d.sda_oe = 1'b0;
    end else if (start_ev) begin
      d.st = (q.busy == '0) ? st_addr : st_idle;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        st_addr, st_reg, st_wdat: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], sda};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == led_i2c_pkg::BYTE_BITS) begin
            d.cnt = 4'h0;
            d.sda_oe = 1'b1;
            d.st = st_ack;
            if (q.st == st_addr) begin
              if (q.sh[7:1] != own_addr) begin
                d.sda_oe = 1'b0;
                d.st = st_wait;
              end else begin
                d.after = q.sh[0] ? st_rdat : st_reg;
              end
            end else if (q.st == st_reg) begin
              d.ptr = q.sh;
              d.after = st_wdat;
            end else begin
              d.ptr = q.ptr + 8'h01;
              d.after = st_wdat;
              // register writes and their side effects
              if (q.ptr == led_i2c_pkg::REG_SLEEP) begin
                d.mem[led_i2c_pkg::REG_SLEEP[6:0]] = q.sh;
                if (q.mode == led_i2c_pkg::mode_active &&
                    q.sh == led_i2c_pkg::SLEEP_STANDBY) begin
                  d.mode = led_i2c_pkg::mode_standby;
                end else if (q.mode == led_i2c_pkg::mode_standby &&
                             q.sh == led_i2c_pkg::SLEEP_ACTIVE) begin
                  d.mode = led_i2c_pkg::mode_active;
                end
              end else if (q.ptr == led_i2c_pkg::REG_SOFT_RST) begin
                if (q.sh == led_i2c_pkg::SOFT_RST_CMD) begin
                  d.mem = TGT_RST.mem;
                  d.mode = led_i2c_pkg::mode_standby;
                  d.busy = 16'(RST_WAIT_CYC);
                end
              end else if (q.ptr == led_i2c_pkg::REG_UPDATE) begin
                // an action, not configuration, so standby drops it
                d.upd = (q.mode == led_i2c_pkg::mode_active);
              end else if (q.ptr == led_i2c_pkg::REG_LED_MODE ||
                           q.ptr == led_i2c_pkg::REG_CLK_SYS ||
                           (q.ptr >= led_i2c_pkg::REG_CFG_FIRST &&
                            q.ptr <= led_i2c_pkg::REG_MEM_LAST)) begin
                d.mem[q.ptr[6:0]] = q.sh;
              end
            end
          end
        end
        st_ack: begin
          if (scl_fall) begin
            d.st = q.after;
            d.sda_oe = 1'b0;
            if (q.after == st_rdat) begin
              d.sh = rd_byte(q);
              d.sda_oe = !d.sh[7];
              d.cnt = 4'h1;
            end
          end
        end
        st_rdat: begin
          if (scl_fall) begin
            if (q.cnt == led_i2c_pkg::BYTE_BITS) begin
              d.sda_oe = 1'b0;
              d.st = st_mack;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = !q.sh[6];
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        st_mack: begin
          if (scl_rise) begin
            d.mack = !sda;
            if (!sda) begin
              d.ptr = q.ptr + 8'h01;
            end
          end else if (scl_fall) begin
            if (q.mack) begin
              d.sh = rd_byte(q);
              d.sda_oe = !d.sh[7];
              d.cnt = 4'h1;
              d.st = st_rdat;
            end else begin
              d.st = st_wait;
            end
          end
        end
        default: begin
          d.sda_oe = 1'b0;
        end
      endcase
    end

    // mode control; the shutdown pin beats everything above
    if (!lvl[led_i2c_pkg::PIN_SHUTDOWN]) begin
      d = tgt_init();
      d.mode = led_i2c_pkg::mode_shutdown;
    end else if (q.mode == led_i2c_pkg::mode_shutdown) begin
      d = tgt_init();
    end
    // internal oscillator after the mode reset, so shutdown never cuts a pin pulse short
    d.div = (q.div == led_i2c_pkg::OSC_DIV_M1) ? 3'h0 : q.div + 3'h1;
    d.clk_o = (d.div < led_i2c_pkg::OSC_HI_CYC);
    d.led_en = (d.mode == led_i2c_pkg::mode_active);
    d.rbusy = (d.busy != '0);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= tgt_init();
    end else begin
      q <= d;
    end
  end

  assign bus.sda_t_o = 1'b0;
  assign bus.sda_t_oe = q.sda_oe;
  assign clock_in_out_pin_o = q.clk_o;
  assign clock_in_out_pin_oe = q.mem[led_i2c_pkg::REG_CLK_SYS[6:0]][led_i2c_pkg::CLK_IO_BIT];
  assign mode = q.mode;
  assign led_drive_en = q.led_en;
  assign core_clk_en = q.core_en;
  assign update_req = q.upd;
  assign reset_busy = q.rbusy;
endmodule : led_target

/* logic/i2c_host.sv */
/*
  two-wire bus controller: one register write, or one register read by a
  restart, per order given over a simple register port.
  assumes a single target that never stretches the clock.
*/
`timescale 1ns/10ps
module i2c_host #(
  parameter int unsigned RST_WAIT_CYC = led_i2c_pkg::SOFT_RST_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  two_wire_if.controller bus,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rd_data
);
  typedef enum logic [1:0] {h_idle, h_start, h_bit, h_stop} hst_e;
  typedef struct packed {
    hst_e st;
    logic [1:0] ph;
    logic [7:0] qc;
    logic [1:0] bi;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ack;
    logic rd;
    logic fast;
    logic [6:0] dev;
    logic [7:0] regad;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic nack;
    logic [led_i2c_pkg::WAIT_W-1:0] hold;
    logic scl_oe;
    logic sda_oe;
    logic [7:0] rdq;
  } hst_s;

  hst_s q;
  hst_s d;
  logic sda;
  logic tick;
  logic busy;
  logic rx;
  logic last;

  // byte sent in each slot; the read data slot is all ones, so data stays released
  function automatic logic [7:0] tx_byte(input hst_s s, input logic [1:0] bi);
    if (bi == led_i2c_pkg::BI_ADDR) begin
      tx_byte = {s.dev, 1'b0};
    end else if (bi == led_i2c_pkg::BI_REG) begin
      tx_byte = s.regad;
    end else if (!s.rd) begin
      tx_byte = s.wdat;
    end else if (bi == led_i2c_pkg::BI_RADDR) begin
      tx_byte = {s.dev, 1'b1};
    end else begin
      tx_byte = 8'hff;
    end
  endfunction : tx_byte

  pin_sync #(
    .RST_LVL(1'b1)
  ) u_sda (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(bus.sda),
    .level(sda)
  );

  // quarter-bit tick at the chosen rate
  assign tick = q.qc == (q.fast ? led_i2c_pkg::QTR_FAST_M1 : led_i2c_pkg::QTR_STD_M1);
  assign busy = (q.st != h_idle) || (q.hold != '0);
  assign rx = q.rd && q.bi == led_i2c_pkg::BI_RDATA;
  assign last = q.rd ? (q.bi == led_i2c_pkg::BI_RDATA) : (q.bi == led_i2c_pkg::BI_RADDR);

  always_comb begin
    d = q;
    d.qc = (tick || q.st == h_idle) ? 8'h00 : q.qc + 8'h01;
    if (q.hold != '0) begin
      d.hold = q.hold - 16'h0001;
    end
    // register port: read data stand in the following cycle
    if (rd_stb) begin
      if (reg_addr == led_i2c_pkg::H_DEV) begin
        d.rdq = {1'b0, q.dev};
      end else if (reg_addr == led_i2c_pkg::H_REG) begin
        d.rdq = q.regad;
      end else if (reg_addr == led_i2c_pkg::H_WDATA) begin
        d.rdq = q.wdat;
      end else if (reg_addr == led_i2c_pkg::H_RDATA) begin
        d.rdq = q.rdat;
      end else if (reg_addr == led_i2c_pkg::H_STATUS) begin
        d.rdq = {6'h00, q.nack, busy};
      end else begin
        d.rdq = 8'h00;
      end
    end
    if (wr_stb) begin
      if (reg_addr == led_i2c_pkg::H_CTRL) begin
        // an order while busy is dropped
        if (wr_data[led_i2c_pkg::CTRL_GO] && !busy) begin
          d.rd = wr_data[led_i2c_pkg::CTRL_READ];
          d.fast = wr_data[led_i2c_pkg::CTRL_FAST];
          d.st = h_start;
          d.ph = 2'h0;
          d.bi = led_i2c_pkg::BI_ADDR;
          d.nack = 1'b0;
        end
      end else if (reg_addr == led_i2c_pkg::H_DEV) begin
        d.dev = wr_data[6:0];
      end else if (reg_addr == led_i2c_pkg::H_REG) begin
        d.regad = wr_data;
      end else if (reg_addr == led_i2c_pkg::H_WDATA) begin
        d.wdat = wr_data;
      end
    end
    // line sequencer, four quarter ticks to each symbol
    if (tick && q.st != h_idle) begin
      d.ph = q.ph + 2'h1;
      case (q.st)
        h_start: begin
          if (q.ph == 2'h0) begin
            d.sda_oe = 1'b0;
          end else if (q.ph == 2'h1) begin
            d.scl_oe = 1'b0;
          end else if (q.ph == 2'h2) begin
            d.sda_oe = 1'b1;
          end else begin
            d.scl_oe = 1'b1;
            d.st = h_bit;
            d.cnt = 4'h0;
            d.sh = tx_byte(q, q.bi);
          end
        end
        h_bit: begin
          if (q.ph == 2'h0) begin
            d.sda_oe = (q.cnt != led_i2c_pkg::BYTE_BITS) && !q.sh[7];
          end else if (q.ph == 2'h1) begin
            d.scl_oe = 1'b0;
          end else if (q.ph == 2'h2) begin
            if (q.cnt == led_i2c_pkg::BYTE_BITS) begin
              d.ack = !sda;
            end else begin
              d.sh = {q.sh[6:0], sda};
            end
          end else begin
            d.scl_oe = 1'b1;
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == led_i2c_pkg::BYTE_BITS) begin
              d.cnt = 4'h0;
              if (rx) begin
                d.rdat = q.sh;
              end
              if (!q.ack && !rx) begin
                d.nack = 1'b1;
                d.st = h_stop;
              end else if (last) begin
                d.st = h_stop;
              end else if (q.rd && q.bi == led_i2c_pkg::BI_REG) begin
                d.bi = led_i2c_pkg::BI_RADDR;
                d.st = h_start;
              end else begin
                d.bi = q.bi + 2'h1;
                d.sh = tx_byte(q, q.bi + 2'h1);
              end
            end
          end
        end
        default: begin
          if (q.ph == 2'h0) begin
            d.sda_oe = 1'b1;
          end else if (q.ph == 2'h1) begin
            d.scl_oe = 1'b0;
          end else if (q.ph == 2'h2) begin
            d.sda_oe = 1'b0;
          end else begin
            d.st = h_idle;
            if (!q.rd && q.regad == led_i2c_pkg::REG_SOFT_RST &&
                q.wdat == led_i2c_pkg::SOFT_RST_CMD) begin
              d.hold = 16'(RST_WAIT_CYC);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.scl_m_o = 1'b0;
  assign bus.scl_m_oe = q.scl_oe;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = q.sda_oe;
  assign rd_data = q.rdq;
endmodule : i2c_host

/* verification/led_link_chk.sv */
/* checker on the two-wire link and the target's mode outputs.
   assumes one clock domain; tb instances it beside the link. */
`timescale 1ns/10ps
module led_link_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_t_oe,
  input wire logic shutdown_pin_n,
  input wire led_i2c_pkg::mode_e mode,
  input wire logic led_drive_en,
  input wire logic update_req,
  input wire logic reset_busy,
  input wire logic clock_in_out_pin_o
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // outputs tied to the mode; sync delay of the pin allowed for
  a_led_active: assert property (led_drive_en |-> mode == led_i2c_pkg::mode_active)
    else $error("led drive outside active mode");
  a_upd_active: assert property (update_req |-> mode == led_i2c_pkg::mode_active)
    else $error("update outside active mode");
  a_pin_shut: assert property (!shutdown_pin_n [*6] |-> mode == led_i2c_pkg::mode_shutdown)
    else $error("pin low but not shut down");
  a_shut_quiet: assert property (mode == led_i2c_pkg::mode_shutdown [*2] |-> !sda_t_oe)
    else $error("acknowledge while shut down");
  // target moves data only while the clock is low, unless the shutdown pin resets it
  a_sda_scl_low: assert property ($changed(sda_t_oe) && mode != led_i2c_pkg::mode_shutdown |-> !scl)
    else $error("target data moved with clock high");
  a_ack_holds: assert property ($rose(sda_t_oe) |-> sda_t_oe [*8])
    else $error("acknowledge too short");
  a_busy_bound: assert property ($rose(reset_busy) |-> reset_busy [*8] ##[1:1000] !reset_busy)
    else $error("reset wait out of bounds");
  a_osc_shape: assert property ($rose(clock_in_out_pin_o) |-> clock_in_out_pin_o [*2] ##1
    !clock_in_out_pin_o [*3] ##1 clock_in_out_pin_o)
    else $error("clock pin shape wrong");
  c_active: cover property (mode == led_i2c_pkg::mode_active);
  c_ack: cover property ($rose(sda_t_oe));
  c_rst_wait: cover property ($rose(reset_busy));
endmodule : led_link_chk

/* verification/tb.sv */
/* bench: i2c_host drives led_target over two_wire_if.
   assumes the package, interface and both ends are compiled first. */
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  localparam logic [7:0] ID_VAL = 8'h5a; // arbitrary value
  localparam logic [6:0] LO = 7'h3a;
  localparam logic [6:0] HI = 7'h3b;
  localparam logic [7:0] CFG = 8'h10;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ext_clk = 1'b0;
  logic addr_sel = 1'b0;
  logic shutdown_pin_n = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rd_data;
  logic [7:0] e_v;
  logic pend_q = 1'b0;
  logic chk_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h0001_513e;
  int err_count = 0;
  int total_checks = 0;
  led_i2c_pkg::mode_e mode;
  logic led_en;
  logic upd;
  logic busy;
  logic osc;
  logic osc_oe;
  logic core_en;
  logic [7:0] upd_n = 8'h00;
  two_wire_if link ();
  always #25 ref_clk = ~ref_clk;
  // external clock for the clock pin, offset so it never meets ref_clk edges
  initial begin
    #7;
    forever #200 ext_clk = ~ext_clk;
  end
  led_target #(.RST_WAIT_CYC(200), .CHIP_ID(ID_VAL)) led_target_inst (.ref_clk(ref_clk),
    .rst(rst), .bus(link), .addr_sel_pin(addr_sel), .shutdown_pin_n(shutdown_pin_n),
    .clock_in_out_pin_i(ext_clk), .clock_in_out_pin_o(osc), .clock_in_out_pin_oe(osc_oe),
    .mode(mode), .led_drive_en(led_en), .core_clk_en(core_en), .update_req(upd),
    .reset_busy(busy));
  i2c_host #(.RST_WAIT_CYC(200)) i2c_host_inst (.ref_clk(ref_clk), .rst(rst), .bus(link),
    .reg_addr(reg_addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data));
  led_link_chk led_link_chk_inst (.ref_clk(ref_clk), .rst(rst), .scl(link.scl),
    .sda_t_oe(link.sda_t_oe), .shutdown_pin_n(shutdown_pin_n), .mode(mode),
    .led_drive_en(led_en), .update_req(upd), .reset_busy(busy), .clock_in_out_pin_o(osc));
  // read data stands one cycle after the strobe: compare with the oldest note
  always @(posedge ref_clk) begin
    if (pend_q) begin
      e_v = exp_q.pop_front();
      `CHK("rd_data", e_v, rd_data)
    end
    pend_q <= rd_stb && chk_q;
  end
  // update pulses counted, so a missing or extra one shows
  always @(posedge ref_clk) begin
    if (upd) upd_n <= upd_n + 8'h01;
  end
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask : wr
  // core enable pulses over 80 cycles: 16 from the oscillator, 10 from the pin
  task automatic count_core(input logic [7:0] e);
    logic [7:0] c;
    int n;
    c = 8'h00;
    for (n = 0; n < 80; n++) begin
      @(posedge ref_clk);
      c = c + {7'h00, core_en};
    end
    `CHK("core_clk_en", e, c)
  endtask : count_core
  task automatic rd(input logic [2:0] a, input logic c, input logic [7:0] e,
      output logic [7:0] v);
    if (c) exp_q.push_back(e);
    @(posedge ref_clk);
    reg_addr <= a;
    rd_stb <= 1'b1;
    chk_q <= c;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(posedge ref_clk);
    v = rd_data;
  endtask : rd
  // one bus order: load the host, go, poll busy under a bound
  task automatic op(input logic [6:0] dv, input logic [7:0] rg, input logic [7:0] d,
      input logic rdop, input logic fast);
    logic [7:0] s;
    int n;
    wr(3'h1, {1'b0, dv});
    wr(3'h2, rg);
    wr(3'h3, d);
    wr(3'h0, {5'h00, fast, rdop, 1'b1});
    s = 8'h01;
    for (n = 0; n < 9000 && s[0] !== 1'b0; n++) rd(3'h5, 1'b0, 8'h00, s);
    if (s[0] !== 1'b0) begin
      err_count++;
      end_of_test();
    end
  endtask : op
  initial begin
    logic [7:0] v;
    logic [7:0] r;
    int sp;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    `CHK("mode", led_i2c_pkg::mode_standby, mode)
    count_core(8'h10);
    for (sp = 0; sp < 2; sp++) begin
      r = xs();
      op(LO, CFG, r, 1'b0, sp[0]);
      op(LO, CFG, 8'h00, 1'b1, sp[0]);
      rd(3'h4, 1'b1, r, v);
    end
    op(LO, 8'h00, 8'h00, 1'b1, 1'b1);
    rd(3'h4, 1'b1, ID_VAL, v);
    $display("test write read done");
    op(HI, CFG, 8'h00, 1'b0, 1'b1);
    rd(3'h5, 1'b1, 8'h02, v);
    addr_sel <= 1'b1;
    op(HI, 8'h01, 8'h00, 1'b1, 1'b1);
    rd(3'h4, 1'b1, 8'h80, v);
    addr_sel <= 1'b0;
    $display("test address done");
    op(LO, 8'h01, 8'h00, 1'b0, 1'b1);
    `CHK("led_en", 1'b1, led_en)
    op(LO, 8'h04, 8'h01, 1'b0, 1'b1);
    `CHK("update_req", 8'h01, upd_n)
    op(LO, 8'h05, 8'h01, 1'b0, 1'b1);
    `CHK("clk_oe", 1'b1, osc_oe)
    op(LO, 8'h05, 8'h02, 1'b0, 1'b1);
    `CHK("clk_oe", 1'b0, osc_oe)
    count_core(8'h0a);
    op(LO, 8'h01, 8'h80, 1'b0, 1'b1);
    `CHK("mode", led_i2c_pkg::mode_standby, mode)
    op(LO, 8'h04, 8'h01, 1'b0, 1'b1);
    `CHK("update_req", 8'h01, upd_n)
    $display("test modes done");
    op(LO, CFG, xs(), 1'b0, 1'b1);
    op(LO, 8'h02, 8'h01, 1'b0, 1'b1);
    op(LO, CFG, 8'h00, 1'b1, 1'b1);
    rd(3'h4, 1'b1, 8'h00, v);
    $display("test soft reset done");
    op(LO, CFG, xs(), 1'b0, 1'b1);
    shutdown_pin_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    `CHK("mode", led_i2c_pkg::mode_shutdown, mode)
    op(LO, CFG, 8'h00, 1'b1, 1'b1);
    rd(3'h5, 1'b1, 8'h02, v);
    shutdown_pin_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    `CHK("mode", led_i2c_pkg::mode_standby, mode)
    op(LO, CFG, 8'h00, 1'b1, 1'b1);
    rd(3'h4, 1'b1, 8'h00, v);
    $display("test shutdown done");
    repeat (3) @(posedge ref_clk);
    end_of_test();
  end
endmodule : tb
